// File: hw/usb_suspend_resume_wake.sv
/*
 Device-role USB link-state logic: suspend detect, remote wake-up with the
 trailing end-of-packet, SE0 drive on host bus reset, and a sticky resume
 flag that wakes the chip from deep sleep. Host-role low-speed-through-hub
 frame corruption is modelled as a flag on the next start-of-frame.
 Assumes line pins are asynchronous; software controls are same-clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usb_link_regs.svh"

// How it works
// R1: Host low-speed via hub corrupts next frame start
// R2: Remote wake-up ends with an appended end-of-packet
// R3: Bus reset drives SE0, both lines low
// R4: Host resume wakes chip from deep sleep
// R5: Resume flag cleared by writing one
// R6: Resume arriving during clear window is lost
// R7: Software clears flag close to sleep entry
// R8: Sleep alternative needs oscillator clock of 20 MHz
// R9: Suspended resume sets sticky flag and interrupt
module usb_suspend_resume_wake
    import usb_link_pkg::*;
#(
    parameter int IDLE_SUSPEND_CYC = `IDLE_SUSPEND_CYC,
    parameter int WAKE_DRIVE_CYC   = `WAKE_DRIVE_CYC,
    parameter int RESET_SE0_CYC    = `RESET_SE0_CYC
) (
    input  wire logic  clock_i,
    input  wire logic  rst_n_i,
    input  wire logic  bus_data_plus_pin_i,
    input  wire logic  bus_data_minus_pin_i,
    output line_drive_t line_o,
    input  wire logic  host_role_i,
    input  wire logic  ls_via_hub_sent_i,
    input  wire logic  sof_sent_i,
    output logic       sof_corrupt_o,
    input  wire logic  remote_wake_req_i,
    input  wire logic  resume_clear_wr_i,
    input  wire logic  deep_sleep_i,
    output logic       suspended_o,
    output logic       resume_status_o,
    output logic       resume_irq_o,
    output logic       wake_o
);
    typedef enum logic [2:0] {ST_ACTIVE, ST_SUSPEND, ST_WAKE, ST_EOP, ST_RESET} state_t;

    localparam int CW = 32;
    localparam int EOP_CYC = `EOP_CYC;

    ////////////////////////////////////////////////////////////////////////////
    logic     dp_s;
    logic     dm_s;
    state_t   state_ff;
    logic [CW-1:0] cnt_ff;
    logic     resume_ff;
    logic     clr_window_ff;
    logic     corrupt_arm_ff;
    logic     corrupt_ff;
    line_drive_t drive_ff;
    logic     se0;
    logic     idle_j;
    logic     resume_k;
    logic     last_se0_ff;

    // Idle bus is J: D+ high, D- low
    sync2 #(
        .RST_VAL (1'b1)
    ) u_sync_dp (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .d_i     (bus_data_plus_pin_i),
        .q_o     (dp_s)
    );

    sync2 #(
        .RST_VAL (1'b0)
    ) u_sync_dm (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .d_i     (bus_data_minus_pin_i),
        .q_o     (dm_s)
    );

    // Full-speed line states seen by the device
    assign se0      = !dp_s && !dm_s;
    assign idle_j   = dp_s && !dm_s;
    assign resume_k = !dp_s && dm_s;

    // Previous synced line state, so a change from J to SE0 restarts the count
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            last_se0_ff <= 1'b0;
        end else begin
            last_se0_ff <= se0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link state machine
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_ACTIVE;
            cnt_ff   <= '0;
        end else if (host_role_i) begin
            state_ff <= ST_ACTIVE;
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                ST_ACTIVE: begin
                    if (se0 && last_se0_ff
                        && cnt_ff >= CW'(RESET_SE0_CYC - 1)) begin
                        state_ff <= ST_RESET;
                        cnt_ff   <= '0;
                    end else if (idle_j && !last_se0_ff
                                 && cnt_ff >= CW'(IDLE_SUSPEND_CYC - 1)) begin
                        state_ff <= ST_SUSPEND;
                        cnt_ff   <= '0;
                    end else if ((se0 && !last_se0_ff) || (idle_j && last_se0_ff)) begin
                        // A J run and an SE0 run never add up
                        cnt_ff <= CW'(1);
                    end else if (se0 || idle_j) begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end else begin
                        cnt_ff <= '0;
                    end
                end
                ST_SUSPEND: begin
                    cnt_ff <= '0;
                    if (se0) begin
                        state_ff <= ST_RESET;
                    end else if (resume_k) begin
                        state_ff <= ST_ACTIVE;
                    end else if (remote_wake_req_i) begin
                        state_ff <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (cnt_ff >= CW'(WAKE_DRIVE_CYC - 1)) begin
                        state_ff <= ST_EOP;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                ST_EOP: begin
                    if (cnt_ff >= CW'(EOP_CYC - 1)) begin
                        state_ff <= ST_ACTIVE;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                ST_RESET: begin
                    cnt_ff <= '0;
                    if (!se0) begin
                        state_ff <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_ff <= ST_ACTIVE;
                    cnt_ff   <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line drive, output enables active low
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            drive_ff <= '{dp_o: 1'b0, dm_o: 1'b0, dp_oe_n: 1'b1, dm_oe_n: 1'b1};
        end else begin
            case (state_ff)
                ST_WAKE: begin
                    drive_ff <= '{dp_o: 1'b0, dm_o: 1'b1, dp_oe_n: 1'b0, dm_oe_n: 1'b0};
                end
                ST_EOP: begin // [R2]
                    drive_ff <= '{dp_o: 1'b0, dm_o: 1'b0, dp_oe_n: 1'b0, dm_oe_n: 1'b0};
                end
                ST_RESET: begin // [R3]
                    drive_ff <= '{dp_o: 1'b0, dm_o: 1'b0, dp_oe_n: 1'b0, dm_oe_n: 1'b0};
                end
                default: begin
                    drive_ff <= '{dp_o: 1'b0, dm_o: 1'b0, dp_oe_n: 1'b1, dm_oe_n: 1'b1};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resume status: set by K or SE0 while suspended, cleared by write of one.
    // The clear opens a window until deep sleep in which events are dropped.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clr_window_ff <= 1'b0;
        end else if (resume_clear_wr_i) begin
            clr_window_ff <= 1'b1; // [R6]
        end else if (deep_sleep_i) begin
            clr_window_ff <= 1'b0; // [R7]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            resume_ff <= 1'b0;
        end else if (state_ff == ST_SUSPEND && (resume_k || se0)
                     && !clr_window_ff && !resume_clear_wr_i) begin
            resume_ff <= 1'b1; // [R9]
        end else if (resume_clear_wr_i) begin
            resume_ff <= 1'b0; // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host role: a low-speed packet through a hub spoils the next frame start
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            corrupt_arm_ff <= 1'b0;
            corrupt_ff     <= 1'b0;
        end else begin
            corrupt_ff <= host_role_i && sof_sent_i && corrupt_arm_ff; // [R1]
            if (!host_role_i) begin
                corrupt_arm_ff <= 1'b0;
            end else if (ls_via_hub_sent_i) begin
                corrupt_arm_ff <= 1'b1;
            end else if (sof_sent_i) begin
                corrupt_arm_ff <= 1'b0;
            end
        end
    end

    assign line_o          = drive_ff;
    assign sof_corrupt_o   = corrupt_ff;
    assign suspended_o     = (state_ff == ST_SUSPEND);
    assign resume_status_o = resume_ff;
    assign resume_irq_o    = resume_ff;
    assign wake_o          = resume_ff && deep_sleep_i; // [R4]
endmodule
`default_nettype wire

// File: hw/usb_link_regs.svh
/*
 Timing counts and field positions for the USB link-state block.
 Assumes a 20 MHz system clock from the main oscillator.
*/
`ifndef USB_LINK_REGS_SVH
`define USB_LINK_REGS_SVH

`define CLK_HZ            20000000
`define MIN_SYS_CLK_HZ    20000000
`define IDLE_SUSPEND_US   3000
`define IDLE_SUSPEND_CYC  ((`IDLE_SUSPEND_US * (`CLK_HZ / 1000000)))
`define WAKE_DRIVE_US     1000
`define WAKE_DRIVE_CYC    ((`WAKE_DRIVE_US * (`CLK_HZ / 1000000)))
`define EOP_NS            1400
`define EOP_CYC           ((`EOP_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RESET_SE0_US      3
`define RESET_SE0_CYC     ((`RESET_SE0_US * (`CLK_HZ / 1000000)))
`define RESUME_FLAG_BIT   0

`endif

// File: hw/usb_link_pkg.sv
/*
 Types for the USB link-state block.
 Assumes the constants header is included by the files that need counts.
*/
package usb_link_pkg;
    typedef struct packed {
        logic dp;
        logic dm;
    } line_pair_t;

    typedef struct packed {
        logic dp_o;
        logic dm_o;
        logic dp_oe_n;
        logic dm_oe_n;
    } line_drive_t;
endpackage

// File: hw/sync2.sv
/*
 Two-flop synchroniser for one pin level.
 Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;
    logic q_ff;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            // Reset to the pin's idle level so no false line state follows reset
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule
`default_nettype wire

// File: tb/usb_link_monitor.sv
/*
 Checker for the USB link-state block.
 Assumes it is bound to every instance of the block; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_link_monitor
    import usb_link_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        bus_data_plus_pin_i,
    input wire logic        bus_data_minus_pin_i,
    input wire line_drive_t line_o,
    input wire logic        host_role_i,
    input wire logic        ls_via_hub_sent_i,
    input wire logic        sof_sent_i,
    input wire logic        sof_corrupt_o,
    input wire logic        remote_wake_req_i,
    input wire logic        resume_clear_wr_i,
    input wire logic        deep_sleep_i,
    input wire logic        suspended_o,
    input wire logic        resume_status_o,
    input wire logic        resume_irq_o,
    input wire logic        wake_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic pin_j   = bus_data_plus_pin_i && !bus_data_minus_pin_i;
    wire logic pin_k   = !bus_data_plus_pin_i && bus_data_minus_pin_i;
    wire logic pin_se0 = !bus_data_plus_pin_i && !bus_data_minus_pin_i;
    sequence k_drive;
        line_o == 4'h4;
    endsequence
    sequence se0_drive;
        line_o == 4'h0;
    endsequence
    a_wake_kdrive: assert property (
        pin_j [*3] ##0 (remote_wake_req_i && suspended_o && !host_role_i) |-> ##2 k_drive [*8])
        else $error("remote wake K drive missing");
    a_wake_eop: assert property (
        k_drive ##1 (line_o != 4'h4) |-> se0_drive [*8])
        else $error("no end-of-packet after wake K");
    a_reset_se0: assert property (
        (pin_se0 && !host_role_i) [*8] |-> ##[0:4] se0_drive)
        else $error("bus reset not answered with SE0");
    a_resume_set: assert property (
        (suspended_o && deep_sleep_i && pin_k && !resume_clear_wr_i) [*3]
        |-> ##[0:2] resume_status_o)
        else $error("resume flag not set");
    a_window_loss: assert property (
        (resume_clear_wr_i && !deep_sleep_i) ##1 !deep_sleep_i [*6] |-> !resume_status_o)
        else $error("resume in clear window not dropped");
    a_clear_wins: assert property (
        resume_clear_wr_i |=> !resume_status_o)
        else $error("resume flag survived clear");
    a_wake_out: assert property (
        wake_o == (resume_status_o && deep_sleep_i))
        else $error("wake output wrong");
    a_irq_follows: assert property (
        resume_irq_o == resume_status_o)
        else $error("resume interrupt differs from resume flag");
    a_sof_corrupt: assert property (
        host_role_i && ls_via_hub_sent_i ##1 sof_sent_i |=> sof_corrupt_o)
        else $error("frame start after hub packet not flagged");
endmodule
bind usb_suspend_resume_wake usb_link_monitor mon_u (
    .clock_i              (clock_i),
    .rst_n_i              (rst_n_i),
    .bus_data_plus_pin_i  (bus_data_plus_pin_i),
    .bus_data_minus_pin_i (bus_data_minus_pin_i),
    .line_o               (line_o),
    .host_role_i          (host_role_i),
    .ls_via_hub_sent_i    (ls_via_hub_sent_i),
    .sof_sent_i           (sof_sent_i),
    .sof_corrupt_o        (sof_corrupt_o),
    .remote_wake_req_i    (remote_wake_req_i),
    .resume_clear_wr_i    (resume_clear_wr_i),
    .deep_sleep_i         (deep_sleep_i),
    .suspended_o          (suspended_o),
    .resume_status_o      (resume_status_o),
    .resume_irq_o         (resume_irq_o),
    .wake_o               (wake_o)
);
`default_nettype wire

// File: tb/usb_host_model.sv
/*
 Host side of the bus: drives J, K or SE0, or lets go.
 Assumes the block's line drive is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import usb_link_pkg::*;
(
    input  wire logic [1:0]  mode_i,
    input  wire line_drive_t line_i,
    output logic             dp_o,
    output logic             dm_o
);
    // 0 J, 1 K, 2 SE0, 3 released: block's drive or D+ pull-up
    // Host wins a clash in modes 0 to 2; only in mode 3 does the block hear its own drive back
    assign dp_o = (mode_i == 2'h3) ? (line_i.dp_oe_n | line_i.dp_o) : (mode_i == 2'h0);
    assign dm_o = (mode_i == 2'h3) ? (!line_i.dm_oe_n & line_i.dm_o) : (mode_i == 2'h1);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 Self-checking bench for the USB link-state block.
 Assumes the host model drives the bus; the bench drives software controls.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import usb_link_pkg::*;
;
    logic        clock_i;
    logic        rst_n_i = 1'b0;
    logic        role    = 1'b0;
    logic        ls      = 1'b0;
    logic        sof     = 1'b0;
    logic        wreq    = 1'b0;
    logic        clr     = 1'b0;
    logic        dsleep  = 1'b0;
    logic [1:0]  mode    = 2'h3;
    logic        dp;
    logic        dm;
    logic        bad;
    logic        susp;
    logic        flag;
    logic        irq;
    logic        wake;
    line_drive_t line;
    int          error_cnt = 0;
    int          n_checks  = 0;
    usb_host_model host_u (.mode_i(mode), .line_i(line), .dp_o(dp), .dm_o(dm));
    usb_suspend_resume_wake #(.IDLE_SUSPEND_CYC(20), .WAKE_DRIVE_CYC(10),
        .RESET_SE0_CYC(4)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .bus_data_plus_pin_i(dp), .bus_data_minus_pin_i(dm), .line_o(line),
        .host_role_i(role), .ls_via_hub_sent_i(ls), .sof_sent_i(sof),
        .sof_corrupt_o(bad), .remote_wake_req_i(wreq), .resume_clear_wr_i(clr),
        .deep_sleep_i(dsleep), .suspended_o(susp), .resume_status_o(flag),
        .resume_irq_o(irq), .wake_o(wake));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task step(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task idle_suspend();
        mode <= 2'h3;
        step(30);
        chk({3'h0, susp}, 4'h1);
        step(1);
    endtask
    task host_k();
        mode <= 2'h1;
        step(6);
        mode <= 2'h0;
    endtask
    task t_remote_wake();
        idle_suspend();
        mode <= 2'h0;
        wreq <= 1'b1;
        step(1);
        wreq <= 1'b0;
        step(5);
        chk(line, 4'h4);
        step(14);
        chk(line, 4'h0);
        step(40);
        chk(line, 4'h3);
    endtask
    task t_resume_deep();
        idle_suspend();
        dsleep <= 1'b1;
        host_k();
        chk({2'h0, flag, irq}, 4'h3);
        chk({3'h0, wake}, 4'h1);
        step(1);
        dsleep <= 1'b0;
        step(1);
        chk({2'h0, flag, wake}, 4'h2);
        step(1);
        clr <= 1'b1;
        step(1);
        clr <= 1'b0;
        step(1);
        chk({3'h0, flag}, 4'h0);
    endtask
    task t_window_loss();
        idle_suspend();
        clr <= 1'b1;
        step(1);
        clr <= 1'b0;
        host_k();
        chk({3'h0, flag}, 4'h0);
        step(1);
        idle_suspend();
        dsleep <= 1'b1;
        host_k();
        chk({2'h0, flag, wake}, 4'h3);
        step(1);
        clr <= 1'b1;
        dsleep <= 1'b0;
        step(1);
        clr <= 1'b0;
    endtask
    task t_bus_reset();
        mode <= 2'h2;
        step(12);
        chk(line, 4'h0);
        mode <= 2'h0;
        step(8);
        chk(line, 4'h3);
    endtask
    task t_sof();
        step(1);
        role <= 1'b1;
        sof <= 1'b1;
        step(1);
        sof <= 1'b0;
        step(1);
        chk({3'h0, bad}, 4'h0);
        step(1);
        ls <= 1'b1;
        step(1);
        ls <= 1'b0;
        sof <= 1'b1;
        step(1);
        sof <= 1'b0;
        step(1);
        chk({3'h0, bad}, 4'h1);
        step(1);
        chk({3'h0, bad}, 4'h0);
        role <= 1'b0;
    endtask
    initial begin
        step(10);
        rst_n_i <= 1'b1;
        step(1);
        chk(line, 4'h3);
        step(1);
        t_remote_wake();
        t_resume_deep();
        t_window_loss();
        t_bus_reset();
        t_sof();
        print_verdict();
    end
    initial begin
        step(3000);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
